// ### shared/crx_defines.svh
/*
  constants for the camera receive error and payload-valid block:
  data type codes, error field positions, crc seed and timing figures.
  assumes nothing; included by the package and the design file.
*/
`ifndef CRX_DEFINES_SVH
`define CRX_DEFINES_SVH

// unknown-type field of the second error status and mask registers
`define CRX_UTYPE_LSB       4'd12
`define CRX_UTYPE_MSB       4'd15
`define CRX_SECOND_ERROR_STATUS_REG_RESET      16'h0000
`define CRX_SECOND_ERROR_MASK_REG_RESET     16'h0000

// data type codes
`define CRX_DT_FRAME_START  6'h00
`define CRX_DT_FRAME_END    6'h01
`define CRX_DT_LINE_START   6'h02
`define CRX_DT_LINE_END     6'h03
`define CRX_DT_SHORT_LAST   6'h0f
`define CRX_DT_NULL         6'h10
`define CRX_DT_BLANK        6'h11
`define CRX_DT_EMBED        6'h12
`define CRX_DT_RSV_LO       6'h13
`define CRX_DT_RSV_HI       6'h17
`define CRX_DT_YUV_LO       6'h18
`define CRX_DT_YUV_HI       6'h1f
`define CRX_DT_RGB_LO       6'h20
`define CRX_DT_RGB_HI       6'h24
`define CRX_DT_RAW_LO       6'h28
`define CRX_DT_RAW_HI       6'h2d
`define CRX_DT_USER_LO      6'h30
`define CRX_DT_USER_HI      6'h37

// checksum seed, footer ordering is low byte first
`define CRX_CRC_SEED        16'hffff

// long blanking threshold in receive clock periods
`define CRX_BLANK_PERIODS   32'h00040000

`endif

// ### shared/crx_pkg.sv
/*
  types for the camera receive error and payload-valid block.
  assumes the defines header sits beside it on the include path.
*/
`include "crx_defines.svh"

package crx_pkg;

  // one received byte of the merged lane stream
  typedef struct packed {
    logic       sop;   // first header byte of a packet
    logic [7:0] data;
  } crx_byte_s;

  // payload word handed to the capture side
  typedef struct packed {
    logic [5:0] dtype;
    logic [7:0] data;
  } crx_pix_s;

  // packet parser states
  typedef enum logic [4:0] {
    CRX_IDLE = 5'b00001,
    CRX_HDR  = 5'b00010,
    CRX_PAY  = 5'b00100,
    CRX_CRC  = 5'b01000,
    CRX_ECC  = 5'b10000
  } crx_state_e;

endpackage

// ### rtl/crx_rx_err.sv
/*
  receive-side packet parser of a camera serial link: unknown data type
  flags with mask and interrupt, payload-valid gating by packet type, and
  payload checksum checking with a byte count that stops between packets.
  assumes lane merging happens upstream: bytes arrive in order, each marked
  by a toggle of byte_strobe, and a packet start marker on its first byte.
  the receive clock is sampled by the core clock only to find its edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "crx_defines.svh"

module crx_rx_err
  import crx_pkg::*;
#(
  parameter int unsigned LANES = 4
)(
  // core clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // link side, asynchronous to clock
  input  wire logic                receive_clock,
  input  wire logic                byte_strobe,
  input  wire crx_pkg::crx_byte_s  link_byte,
  // software side
  input  wire logic [15:0]         second_error_mask_reg,
  input  wire logic [3:0]          unknown_type_clear,
  output logic [15:0]              second_error_status_reg,
  output logic                     error_irq,
  output logic                     crc_error_flag,
  input  wire logic                crc_error_clear,
  // capture side
  output logic                     payload_valid,
  output crx_pkg::crx_pix_s        payload_word,
  output logic [15:0]              payload_count,
  output logic [5:0]               last_dtype
);

  // two-flop synchronisers for the link signals
  logic [2:0]  rclk_q;
  logic [2:0]  stb_q;
  crx_byte_s   byte_m_q;
  crx_byte_s   byte_s_q;
  logic [1:0]  vc_q;

  always_ff @(posedge clock)
  begin
    rclk_q   <= {rclk_q[1:0], receive_clock};
    stb_q    <= {stb_q[1:0], byte_strobe};
    byte_m_q <= link_byte;
    byte_s_q <= byte_m_q;
  end

  // a byte is taken when the synchronised strobe toggles
  wire        byte_take  = stb_q[2] ^ stb_q[1];
  wire        rclk_rise  = rclk_q[1] & ~rclk_q[2];
  wire [7:0]  bdata      = byte_s_q.data;

  // data type decoding used for both the error and the valid gate
  function automatic logic dt_known(input logic [5:0] dt);
    dt_known = (dt <= `CRX_DT_SHORT_LAST)
            || (dt >= `CRX_DT_NULL    && dt <= `CRX_DT_RSV_HI)
            || (dt >= `CRX_DT_YUV_LO  && dt <= `CRX_DT_YUV_HI)
            || (dt >= `CRX_DT_RGB_LO  && dt <= `CRX_DT_RGB_HI)
            || (dt >= `CRX_DT_RAW_LO  && dt <= `CRX_DT_RAW_HI)
            || (dt >= `CRX_DT_USER_LO && dt <= `CRX_DT_USER_HI);
  endfunction

  function automatic logic dt_long(input logic [5:0] dt);
    dt_long = dt > `CRX_DT_SHORT_LAST;
  endfunction

  // ccitt crc over one byte, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ 16'h8408;
      else
        r = r >> 1;
    end
    crc_byte = r;
  endfunction

  // parser state
  crx_state_e  state_q;
  logic [1:0]  hidx_q;
  logic [5:0]  dtype_q;
  logic [15:0] wc_q;
  logic [15:0] cnt_q;
  logic [15:0] crc_q;
  logic [7:0]  crc_lo_q;
  logic        cidx_q;
  logic [31:0] idle_q;

  // header bytes: data type/vc, word count low, word count high, ecc
  // the word count high byte is the third byte of the header, taken at index 1
  wire         hdr_done   = byte_take && state_q == CRX_HDR && hidx_q == 2'd1;
  wire [15:0]  wc_full    = {bdata, wc_q[7:0]};
  wire         pay_last   = byte_take && state_q == CRX_PAY && cnt_q == wc_q - 16'h0001;
  wire         crc_done   = byte_take && state_q == CRX_CRC && cidx_q;
  wire [15:0]  crc_rx     = {bdata, crc_lo_q};
  // counting stops outside the payload phase, so idle gaps never wrap it
  wire         cnt_run    = byte_take && state_q == CRX_PAY;
  wire         is_blank   = dtype_q == `CRX_DT_NULL || dtype_q == `CRX_DT_BLANK;
  wire         unk_evt    = hdr_done && !dt_known(dtype_q);
  wire [1:0]   unk_bit    = vc_q;
  // the checksum is judged once per packet only, independent of idle time
  wire         crc_bad    = crc_done && crc_rx != crc_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q  <= CRX_IDLE;
      hidx_q   <= 2'd0;
      dtype_q  <= 6'h00;
      vc_q     <= 2'd0;
      wc_q     <= 16'h0000;
      cnt_q    <= 16'h0000;
      crc_q    <= `CRX_CRC_SEED;
      crc_lo_q <= 8'h00;
      cidx_q   <= 1'b0;
    end
    else if (byte_take)
    begin
      if (byte_s_q.sop)
      begin
        // a start marker always restarts the header
        state_q <= CRX_HDR;
        hidx_q  <= 2'd0;
        dtype_q <= bdata[5:0];
        vc_q    <= bdata[7:6];
        cnt_q   <= 16'h0000;
      end
      else
      begin
        unique case (state_q)
          CRX_IDLE: state_q <= CRX_IDLE;
          CRX_HDR:
          begin
            hidx_q <= hidx_q + 2'd1;
            if (hidx_q == 2'd0)
              wc_q[7:0] <= bdata;
            if (hidx_q == 2'd1)
            begin
              wc_q    <= wc_full;
              state_q <= CRX_ECC;
            end
          end
          CRX_ECC:
          begin
            crc_q  <= `CRX_CRC_SEED;
            cidx_q <= 1'b0;
            if (dt_long(dtype_q) && wc_q != 16'h0000)
              state_q <= CRX_PAY;
            else if (dt_long(dtype_q))
              state_q <= CRX_CRC;
            else
              state_q <= CRX_IDLE;
          end
          CRX_PAY:
          begin
            cnt_q <= cnt_q + 16'h0001;
            crc_q <= crc_byte(crc_q, bdata);
            if (pay_last)
              state_q <= CRX_CRC;
          end
          CRX_CRC:
          begin
            crc_lo_q <= bdata;
            cidx_q   <= 1'b1;
            if (cidx_q)
              state_q <= CRX_IDLE;
          end
        endcase
      end
    end
  end

  // receive clock periods spent idle, a diagnostic of blanking length only
  always_ff @(posedge clock)
  begin
    if (reset || (byte_take && byte_s_q.sop))
      idle_q <= 32'h0;
    else if (rclk_rise && state_q == CRX_IDLE && idle_q != `CRX_BLANK_PERIODS)
      idle_q <= idle_q + 32'h1;
  end

  // sticky unknown-type flags, one per virtual channel; set wins over clear
  logic [3:0] unk_q;
  wire  [3:0] unk_set = unk_evt ? (4'b0001 << unk_bit) : 4'b0000;

  always_ff @(posedge clock)
  begin
    if (reset)
      unk_q <= 4'h0;
    else
      unk_q <= (unk_q & ~unknown_type_clear) | unk_set;
  end

  // status word and masked interrupt
  wire [3:0] mask_utype = second_error_mask_reg[`CRX_UTYPE_MSB:`CRX_UTYPE_LSB];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      second_error_status_reg <= `CRX_SECOND_ERROR_STATUS_REG_RESET;
      error_irq               <= 1'b0;
    end
    else
    begin
      second_error_status_reg <= {unk_q, 12'h000};
      error_irq               <= |(unk_q & ~mask_utype);
    end
  end

  // checksum error flag, set wins over clear
  always_ff @(posedge clock)
  begin
    if (reset)
      crc_error_flag <= 1'b0;
    else
      crc_error_flag <= crc_bad | (crc_error_flag & ~crc_error_clear);
  end

  // payload output, null and blanking payload never strobes
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      payload_valid <= 1'b0;
      payload_word  <= '0;
      payload_count <= 16'h0000;
      last_dtype    <= 6'h00;
    end
    else
    begin
      payload_valid <= cnt_run && !is_blank;
      if (cnt_run)
        payload_word <= '{dtype: dtype_q, data: bdata};
      payload_count <= cnt_q;
      if (hdr_done)
        last_dtype <= dtype_q;
    end
  end

endmodule
`default_nettype wire

// ### tb/crx_rx_err_chk.sv
/* port checker for crx_rx_err; bound to every instance of it.
   assumes the software clears reach the design on the core clock */
`timescale 1ns/100ps
`default_nettype none
module crx_rx_err_chk
  import crx_pkg::*;
#(parameter int unsigned LANES = 4)(
  // clock and reset
  input wire logic              clock,
  input wire logic              reset,
  // software side
  input wire logic [15:0]       second_error_mask_reg,
  input wire logic [3:0]        unknown_type_clear,
  input wire logic [15:0]       second_error_status_reg,
  input wire logic              error_irq,
  input wire logic              crc_error_flag,
  input wire logic              crc_error_clear,
  // capture side
  input wire logic              payload_valid,
  input wire crx_pkg::crx_pix_s payload_word,
  input wire logic [15:0]       payload_count
);
  // unmasked flags; irq may lag them by one cycle
  wire logic [3:0] live = second_error_status_reg[15:12] & ~second_error_mask_reg[15:12];
  wire logic [3:0] st   = second_error_status_reg[15:12];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence live_s; live != 4'h0; endsequence
  irq_raise_a: assert property (live_s [*2] |-> error_irq) else $error("irq missing");
  irq_mask_a: assert property ((live == 4'h0) [*2] |-> !error_irq) else $error("masked irq");
  stat_field_a: assert property (second_error_status_reg[11:0] == 12'h000) else $error("stray status");
  flag_hold_a: assert property (($past(st) & ~st & ~$past(unknown_type_clear, 2)) == 4'h0)
    else $error("flag lost");
  pv_type_a: assert property (payload_valid |-> !(payload_word.dtype inside {6'h10, 6'h11}))
    else $error("valid on blanking");
  pv_pulse_a: assert property (payload_valid |=> !payload_valid) else $error("valid too long");
  count_step_a: assert property ($changed(payload_count) |->
    payload_count == $past(payload_count) + 16'h0001 || payload_count == 16'h0000) else $error("count jump");
  crc_hold_a: assert property ($fell(crc_error_flag) |-> $past(crc_error_clear)) else $error("crc lost");
endmodule
bind crx_rx_err crx_rx_err_chk #(.LANES(LANES)) u_chk (.clock(clock), .reset(reset),
  .second_error_mask_reg(second_error_mask_reg), .unknown_type_clear(unknown_type_clear),
  .second_error_status_reg(second_error_status_reg), .error_irq(error_irq), .crc_error_flag(crc_error_flag),
  .crc_error_clear(crc_error_clear), .payload_valid(payload_valid), .payload_word(payload_word),
  .payload_count(payload_count));
`default_nettype wire

// ### tb/crx_sensor_model.sv
/* sensor transmitter model; bytes every 11 core cycles, link clock from any packet start until a frame end.
   assumes the bench calls pkt from one process at a time */
`timescale 1ns/100ps
`default_nettype none
module crx_sensor_model
  import crx_pkg::*;
(
  // core clock paces the model
  input wire logic         clock,
  // link side
  output logic             receive_clock,
  output logic             byte_strobe,
  output crx_pkg::crx_byte_s link_byte
);
  logic rc_on = 1'b0;
  initial {receive_clock, byte_strobe, link_byte} = '0;
  // link clock stands low between frames
  always #40 receive_clock = rc_on ? ~receive_clock : 1'b0;
  // data settles a cycle before the toggle that delivers it
  task automatic put(input logic s, input logic [7:0] d);
    @(negedge clock) link_byte <= {s, d};
    @(negedge clock) byte_strobe <= ~byte_strobe;
    repeat (9) @(negedge clock);
  endtask
  // one packet; long types carry n payload bytes and a footer
  task automatic pkt(input logic [1:0] vc, input logic [5:0] dt, input int n, input logic bad);
    logic [15:0] c;
    logic [7:0]  b;
    c = 16'hffff;
    rc_on = 1'b1;
    put(1'b1, {vc, dt});
    put(1'b0, n[7:0]);
    put(1'b0, n[15:8]);
    put(1'b0, 8'h00);
    if (dt > 6'h0f)
    begin
      for (int i = 0; i < n; i++)
      begin
        b = 8'h30 + i[7:0];
        put(1'b0, b);
        for (int j = 0; j < 8; j++)
          c = (c[0] ^ b[j]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      if (bad) c = ~c;
      put(1'b0, c[7:0]);
      put(1'b0, c[15:8]);
    end
    link_byte <= ~link_byte;       // inverted after the last byte: no stale byte
    if (dt == 6'h01) rc_on = 1'b0; // frame end: blanking kept short
  endtask
endmodule
`default_nettype wire

// ### tb/crx_rx_err_tb.sv
/* bench for crx_rx_err; the sensor model drives the link side */
`timescale 1ns/100ps
`default_nettype none
module crx_rx_err_tb;
  import crx_pkg::*;
  logic clock = 1'b0, reset = 1'b1, byte_strobe, receive_clock, error_irq, crc_error_flag, payload_valid;
  logic crc_error_clear = 1'b0;
  logic [15:0] mask = 16'h0000, status, payload_count;
  logic [3:0] utc = 4'h0;
  logic [5:0] last_dtype;
  crx_byte_s link_byte;
  crx_pix_s payload_word;
  int error_cnt = 0, n_checks = 0, pv_cnt = 0;
  always #4 clock = ~clock;
  // payload strobes seen
  always @(negedge clock) if (payload_valid) pv_cnt++;
  crx_sensor_model u_crx_sensor_model (.clock(clock), .receive_clock(receive_clock),
    .byte_strobe(byte_strobe), .link_byte(link_byte));
  crx_rx_err #(.LANES(4)) u_crx_rx_err (.clock(clock), .reset(reset), .receive_clock(receive_clock),
    .byte_strobe(byte_strobe), .link_byte(link_byte), .second_error_mask_reg(mask),
    .unknown_type_clear(utc), .second_error_status_reg(status), .error_irq(error_irq),
    .crc_error_flag(crc_error_flag), .crc_error_clear(crc_error_clear), .payload_valid(payload_valid),
    .payload_word(payload_word), .payload_count(payload_count), .last_dtype(last_dtype));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr();
    @(negedge clock) {utc, crc_error_clear} <= 5'h1f;
    @(negedge clock) {utc, crc_error_clear} <= 5'h00;
    repeat (2) @(negedge clock);
  endtask
  // every data type code, virtual channel from its low bits
  task automatic t_types();
    logic u;
    for (int i = 0; i < 64; i++)
    begin
      u = (i > 'h24 && i < 'h28) || (i > 'h2d && i < 'h30) || i > 'h37;
      clr();
      u_crx_sensor_model.pkt(i[1:0], i[5:0], 0, 1'b0);
      chk(status, {3'b000, u, 12'h000} << i[1:0]);
      chk(crc_error_flag, 1'b0);
      chk(error_irq, u);
      chk(last_dtype, i[5:0]);
    end
    chk(crc_error_flag, 1'b0);
    $display("t_types done");
  endtask
  task automatic t_mask();
    clr();
    mask <= 16'h2000;
    u_crx_sensor_model.pkt(2'd1, 6'h3a, 0, 1'b0);
    chk(status, 16'h2000);
    chk(error_irq, 1'b0);
    mask <= 16'h0000;
    repeat (3) @(negedge clock);
    chk(error_irq, 1'b1);
    clr();
    chk(status, 16'h0000);
    chk(error_irq, 1'b0);
    $display("t_mask done");
  endtask
  task automatic t_valid();
    clr();
    pv_cnt = 0;
    u_crx_sensor_model.pkt(2'd0, 6'h00, 0, 1'b0);
    u_crx_sensor_model.pkt(2'd0, 6'h10, 4, 1'b0);
    u_crx_sensor_model.pkt(2'd0, 6'h11, 3, 1'b0);
    chk(pv_cnt, 0);
    u_crx_sensor_model.pkt(2'd0, 6'h2a, 5, 1'b0);
    chk(pv_cnt, 5);
    chk(payload_word, {6'h2a, 8'h34});
    chk(payload_count, 16'd5);
    repeat (2000) @(negedge clock);
    chk(payload_count, 16'd5);
    u_crx_sensor_model.pkt(2'd0, 6'h01, 0, 1'b0);
    chk(crc_error_flag, 1'b0);
    u_crx_sensor_model.pkt(2'd0, 6'h2a, 2, 1'b1);
    chk(crc_error_flag, 1'b1);
    clr();
    chk(crc_error_flag, 1'b0);
    $display("t_valid done");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog well past the expected run length
  initial
  begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(negedge clock);
    reset <= 1'b0;
    repeat (3) @(negedge clock);
    t_types();
    t_mask();
    t_valid();
    finish_test();
  end
endmodule
`default_nettype wire
